// file: rtl/rcsr_top.sv
// Behaviour
// - Debug-forced reset leaves every reset-cause flag cleared.
// - Enabled watchdog: cause-register write other than 55/AA resets.
// - Writing 55 then AA restarts watchdog, cause flags untouched.
// - Power-on reset sets bits 7 and 1, clears the rest.
// - Enabled low-voltage trip resets; sets bit 1, keeps bit 7.
// - Other resets clear bits 7,1; set bits 6..3 from active sources.
// - External reset pin low sets bit 6.
// - Watchdog timeout sets bit 5; no watchdog reset when disabled.
// - Bad opcode, disabled stop or background instruction outside background mode sets bit 4.
// - Access to unimplemented address resets and sets bit 3.
// - Force-reset register ignores CPU writes; reads return 00.
// - Debug host writing 1 to bit 0 forces full reset.
// - Options register takes first write after reset only; always readable.
// - Options bits 7:6 with clock select choose watchdog timeout.
// - Options bit 5 enables stop; disabled stop forces bad opcode reset.
// - Options bit 2 routes two-wire bus: 0 port A, 1 port B.
// - Window mode, bus clock source only: write in first 75% of period resets.
`timescale 1ns/10ps
`default_nettype none
module rcsr_top #(
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_SLOW_CYC0 = 20'h00020,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_SLOW_CYC1 = 20'h00100,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_SLOW_CYC2 = 20'h00400,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_SLOW_CYC3 = 20'h01000,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_BUS_CYC0 = 20'h02000,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_BUS_CYC1 = 20'h08000,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_BUS_CYC2 = 20'h20000,
  parameter logic [rcsr_pkg::RCSR_WDOG_W-1:0] WDOG_BUS_CYC3 = 20'h40000
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic [7:0] cpu_rdata_out,
  input wire logic bdc_wr_in,
  input wire logic [1:0] bdc_addr_in,
  input wire logic [7:0] bdc_wdata_in,
  input wire logic ext_reset_n_in,
  input wire logic low_voltage_in,
  input wire logic low_voltage_reset_enable_in,
  input wire logic bad_opcode_in,
  input wire logic stop_instr_in,
  input wire logic background_instr_in,
  input wire logic background_mode_enable_in,
  input wire logic bad_address_in,
  input wire logic watchdog_enable_in,
  input wire logic watchdog_clock_select_in,
  input wire logic watchdog_window_mode_in,
  input wire logic slow_tick_in,
  output logic sys_reset_out,
  output logic stop_mode_enable_out,
  output logic [1:0] watchdog_timeout_select_out,
  output logic iic_on_port_a_out,
  output logic iic_on_port_b_out
);

  logic [1:0] rst_sync_ff;
  logic rst_n;

  rcsr_pkg::rcsr_regs_t cur_ff;
  rcsr_pkg::rcsr_regs_t nxt_ff;

  logic running;
  logic cpu_wr_cause;
  logic cpu_wr_opts;
  logic wd_restart;
  logic wd_expire;
  logic wd_window_open;
  logic wd_tick;
  logic wd_windowed;
  logic [rcsr_pkg::RCSR_WDOG_W-1:0] wd_period;
  logic [1:0] tsel;
  logic wr_is_first;
  logic wr_is_second;
  logic wr_bad_value;
  logic wr_too_early;
  logic src_force;
  logic src_lvd;
  logic src_pin;
  logic src_wdog;
  logic src_bad_opcode_flag;
  logic src_bad_address_flag;
  logic any_src;
  logic hold_release;
  logic [7:0] entry_cause;

  // Two-stage release of the external asynchronous reset
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign running = (cur_ff.state == rcsr_pkg::RCSR_RUN);
  assign cpu_wr_cause = running && cpu_wr_in &&
    (cpu_addr_in == rcsr_pkg::RCSR_IDX_CAUSE);
  assign cpu_wr_opts = running && cpu_wr_in &&
    (cpu_addr_in == rcsr_pkg::RCSR_IDX_OPTIONS);

  assign tsel = {cur_ff.opts[rcsr_pkg::RCSR_OPT_TSEL_HI],
                 cur_ff.opts[rcsr_pkg::RCSR_OPT_TSEL_LO]};

  // Timeout from write-once select and clock select
  always_comb begin
    wd_period = WDOG_SLOW_CYC0;
    unique case ({watchdog_clock_select_in, tsel})
      3'h0: wd_period = WDOG_SLOW_CYC0;
      3'h1: wd_period = WDOG_SLOW_CYC1;
      3'h2: wd_period = WDOG_SLOW_CYC2;
      3'h3: wd_period = WDOG_SLOW_CYC3;
      3'h4: wd_period = WDOG_BUS_CYC0;
      3'h5: wd_period = WDOG_BUS_CYC1;
      3'h6: wd_period = WDOG_BUS_CYC2;
      3'h7: wd_period = WDOG_BUS_CYC3;
    endcase
  end

  // Bus clock source counts every cycle; slow source counts ticks
  assign wd_tick = watchdog_clock_select_in | slow_tick_in;
  // Window mode only applies when the bus clock feeds the watchdog
  assign wd_windowed = watchdog_window_mode_in & watchdog_clock_select_in;

  assign wr_is_first = (cpu_wdata_in == rcsr_pkg::RCSR_SERVICE_FIRST);
  assign wr_is_second = (cpu_wdata_in == rcsr_pkg::RCSR_SERVICE_SECOND);
  assign wr_bad_value = cpu_wr_cause && !wr_is_first && !wr_is_second;
  assign wr_too_early = cpu_wr_cause && wd_windowed &&
    !wd_window_open;
  assign wd_restart = cpu_wr_cause && wr_is_second && cur_ff.armed &&
    !wr_too_early;

  rcsr_wdog u_wdog (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .restart_in(wd_restart),
    .run_in(watchdog_enable_in && running),
    .tick_in(wd_tick),
    .period_in(wd_period),
    .expire_out(wd_expire),
    .window_open_out(wd_window_open)
  );

  // Reset sources, sampled only while running
  assign src_force = running && bdc_wr_in &&
    (bdc_addr_in == rcsr_pkg::RCSR_IDX_FORCE) &&
    bdc_wdata_in[rcsr_pkg::RCSR_FORCE_BIT];
  assign src_lvd = low_voltage_reset_enable_in && low_voltage_in;
  assign src_pin = !ext_reset_n_in;
  assign src_wdog = watchdog_enable_in &&
    (wd_expire || wr_bad_value || wr_too_early);
  assign src_bad_opcode_flag = bad_opcode_in ||
    (stop_instr_in && !cur_ff.opts[rcsr_pkg::RCSR_OPT_STOP]) ||
    (background_instr_in && !background_mode_enable_in);
  assign src_bad_address_flag = bad_address_in;
  assign any_src = src_force || src_lvd || src_pin || src_wdog ||
    src_bad_opcode_flag || src_bad_address_flag;

  // Flags captured on reset entry; debug force outranks low voltage, which outranks the rest
  always_comb begin
    entry_cause = 8'h00;
    if (src_force) begin
      entry_cause = 8'h00;
    end else if (src_lvd) begin
      entry_cause[rcsr_pkg::RCSR_CAUSE_POR] =
        cur_ff.cause[rcsr_pkg::RCSR_CAUSE_POR];
      entry_cause[rcsr_pkg::RCSR_CAUSE_LVD] = 1'b1;
    end else begin
      entry_cause[rcsr_pkg::RCSR_CAUSE_PIN] = src_pin;
      entry_cause[rcsr_pkg::RCSR_CAUSE_WDOG] = src_wdog;
      entry_cause[rcsr_pkg::RCSR_CAUSE_BAD_OPCODE_FLAG] = src_bad_opcode_flag;
      entry_cause[rcsr_pkg::RCSR_CAUSE_BAD_ADDRESS_FLAG] = src_bad_address_flag;
    end
  end

  // Pin and low-voltage resets stretch the hold until they go away
  assign hold_release = (cur_ff.hold_cnt == 8'h00) && ext_reset_n_in &&
    !src_lvd;

  always_comb begin
    nxt_ff = cur_ff;
    unique case (cur_ff.state)
      rcsr_pkg::RCSR_RUN: begin
        if (any_src) begin
          nxt_ff.state = rcsr_pkg::RCSR_HOLD;
          nxt_ff.hold_cnt = rcsr_pkg::RCSR_RST_HOLD_CYC - 8'h01;
          nxt_ff.cause = entry_cause;
          nxt_ff.sys_reset = 1'b1;
          nxt_ff.armed = 1'b0;
        end else begin
          if (cpu_wr_cause) begin
            // A first write arms; any other value disarms
            nxt_ff.armed = wr_is_first;
          end
          if (cpu_wr_opts && !cur_ff.opts_locked) begin
            nxt_ff.opts = cpu_wdata_in & rcsr_pkg::RCSR_OPT_WR_MASK;
            nxt_ff.opts_locked = 1'b1;
          end
        end
      end
      rcsr_pkg::RCSR_HOLD: begin
        // Every reset re-initialises the options and service sequence
        nxt_ff.opts = rcsr_pkg::RCSR_OPT_RESET;
        nxt_ff.opts_locked = 1'b0;
        nxt_ff.armed = 1'b0;
        if (cur_ff.hold_cnt != 8'h00) begin
          nxt_ff.hold_cnt = cur_ff.hold_cnt - 8'h01;
        end
        if (hold_release) begin
          nxt_ff.state = rcsr_pkg::RCSR_RUN;
          nxt_ff.sys_reset = 1'b0;
        end
      end
    endcase

    nxt_ff.iic_a = !nxt_ff.opts[rcsr_pkg::RCSR_OPT_IIC];
    nxt_ff.iic_b = nxt_ff.opts[rcsr_pkg::RCSR_OPT_IIC];

    // Registered read data, one cycle after the strobe
    if (cpu_rd_in) begin
      unique case (cpu_addr_in)
        rcsr_pkg::RCSR_IDX_CAUSE:
          nxt_ff.rdata = cur_ff.cause & rcsr_pkg::RCSR_CAUSE_RD_MASK;
        rcsr_pkg::RCSR_IDX_FORCE:
          nxt_ff.rdata = rcsr_pkg::RCSR_FORCE_RD_VAL;
        rcsr_pkg::RCSR_IDX_OPTIONS:
          nxt_ff.rdata = cur_ff.opts;
        default:
          nxt_ff.rdata = 8'h00;
      endcase
    end
  end

  // CPU writes to the force-reset index decode to nothing by design
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= rcsr_pkg::RCSR_REGS_POR;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign cpu_rdata_out = cur_ff.rdata;
  assign sys_reset_out = cur_ff.sys_reset;
  assign stop_mode_enable_out = cur_ff.opts[rcsr_pkg::RCSR_OPT_STOP];
  assign watchdog_timeout_select_out = tsel;
  assign iic_on_port_a_out = cur_ff.iic_a;
  assign iic_on_port_b_out = cur_ff.iic_b;

endmodule
`default_nettype wire

// file: include/rcsr_pkg.sv
`default_nettype none
package rcsr_pkg;

  // Register indices on the core bus and the background link
  localparam logic [1:0] RCSR_IDX_CAUSE = 2'h0;
  localparam logic [1:0] RCSR_IDX_FORCE = 2'h1;
  localparam logic [1:0] RCSR_IDX_OPTIONS = 2'h2;

  // reset_cause_status bit positions
  localparam int RCSR_CAUSE_POR = 7;
  localparam int RCSR_CAUSE_PIN = 6;
  localparam int RCSR_CAUSE_WDOG = 5;
  localparam int RCSR_CAUSE_BAD_OPCODE_FLAG = 4;
  localparam int RCSR_CAUSE_BAD_ADDRESS_FLAG = 3;
  localparam int RCSR_CAUSE_LVD = 1;

  // system_options_one bit positions
  localparam int RCSR_OPT_TSEL_HI = 7;
  localparam int RCSR_OPT_TSEL_LO = 6;
  localparam int RCSR_OPT_STOP = 5;
  localparam int RCSR_OPT_IIC = 2;

  // debug_force_reset bit position
  localparam int RCSR_FORCE_BIT = 0;

  localparam logic [7:0] RCSR_CAUSE_POR_VAL = 8'h82;
  localparam logic [7:0] RCSR_CAUSE_RD_MASK = 8'hFA;
  localparam logic [7:0] RCSR_OPT_RESET = 8'hC0;
  localparam logic [7:0] RCSR_OPT_WR_MASK = 8'hE4;
  localparam logic [7:0] RCSR_FORCE_RD_VAL = 8'h00;
  localparam logic [7:0] RCSR_SERVICE_FIRST = 8'h55;
  localparam logic [7:0] RCSR_SERVICE_SECOND = 8'hAA;

  // Timing at the core clock
  localparam int RCSR_CLK_MHZ = 200;
  localparam int RCSR_RST_HOLD_NS = 1000;
  localparam logic [7:0] RCSR_RST_HOLD_CYC =
    8'((RCSR_RST_HOLD_NS * RCSR_CLK_MHZ + 999) / 1000);

  localparam int RCSR_WDOG_W = 20;

  typedef enum logic {
    RCSR_RUN = 1'b0,
    RCSR_HOLD = 1'b1
  } rcsr_state_t;

  typedef struct packed {
    rcsr_state_t state;
    logic [7:0] hold_cnt;
    logic [7:0] cause;
    logic [7:0] opts;
    logic opts_locked;
    logic armed;
    logic [7:0] rdata;
    logic sys_reset;
    logic iic_a;
    logic iic_b;
  } rcsr_regs_t;

  localparam rcsr_regs_t RCSR_REGS_POR = '{
    state: RCSR_RUN,
    hold_cnt: 8'h00,
    cause: RCSR_CAUSE_POR_VAL,
    opts: RCSR_OPT_RESET,
    opts_locked: 1'b0,
    armed: 1'b0,
    rdata: 8'h00,
    sys_reset: 1'b0,
    iic_a: ~RCSR_OPT_RESET[RCSR_OPT_IIC],
    iic_b: RCSR_OPT_RESET[RCSR_OPT_IIC]
  };

  typedef struct packed {
    logic [RCSR_WDOG_W-1:0] cnt;
    logic expire;
  } rcsr_wdog_regs_t;

endpackage
`default_nettype wire

// file: rtl/rcsr_wdog.sv
`timescale 1ns/10ps
`default_nettype none
module rcsr_wdog (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [rcsr_pkg::RCSR_WDOG_W-1:0] period_in,
  output logic expire_out,
  output logic window_open_out
);

  rcsr_pkg::rcsr_wdog_regs_t cur_ff;
  rcsr_pkg::rcsr_wdog_regs_t nxt_ff;
  logic [rcsr_pkg::RCSR_WDOG_W-1:0] cnt_inc;
  logic [rcsr_pkg::RCSR_WDOG_W-1:0] window_start;

  assign cnt_inc = cur_ff.cnt + 1'b1;
  // Last quarter of the period is the service window
  assign window_start = period_in - (period_in >> 2);

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.expire = 1'b0;
    if (restart_in || !run_in) begin
      nxt_ff.cnt = '0;
    end else if (tick_in) begin
      if (cnt_inc >= period_in) begin
        nxt_ff.cnt = '0;
        nxt_ff.expire = 1'b1;
      end else begin
        nxt_ff.cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign expire_out = cur_ff.expire;
  assign window_open_out = (cur_ff.cnt >= window_start);

endmodule
`default_nettype wire

// file: testbench/rcsr_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rcsr_top_checker (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic [7:0] cpu_rdata_out,
  input wire logic bdc_wr_in,
  input wire logic [1:0] bdc_addr_in,
  input wire logic [7:0] bdc_wdata_in,
  input wire logic bad_opcode_in,
  input wire logic stop_instr_in,
  input wire logic bad_address_in,
  input wire logic watchdog_enable_in,
  input wire logic sys_reset_out,
  input wire logic stop_mode_enable_out,
  input wire logic [1:0] watchdog_timeout_select_out,
  input wire logic iic_on_port_a_out,
  input wire logic iic_on_port_b_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [8:0] hold_cnt_ff;
  wire logic idle = !sys_reset_out;
  // Counts held cycles; too long a sequence for a repetition
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) hold_cnt_ff <= 9'h000;
    else if (sys_reset_out) hold_cnt_ff <= hold_cnt_ff + 9'h001;
    else hold_cnt_ff <= 9'h000;
  end
  force_read_a:
  assert property (cpu_rd_in && idle && cpu_addr_in == 2'h1
    |=> cpu_rdata_out == 8'h00) else $error("force register read not zero");
  cause_gap_a:
  assert property (cpu_rd_in && idle && cpu_addr_in == 2'h0
    |=> cpu_rdata_out[2] == 1'b0 && cpu_rdata_out[0] == 1'b0)
    else $error("cause register empty bits not zero");
  bad_op_a:
  assert property (bad_opcode_in && idle |=> sys_reset_out)
    else $error("bad opcode did not reset");
  bad_addr_a:
  assert property (bad_address_in && idle |=> sys_reset_out)
    else $error("bad address did not reset");
  stop_off_a:
  assert property (stop_instr_in && !stop_mode_enable_out && idle
    |=> sys_reset_out) else $error("disabled stop did not reset");
  bad_value_a:
  assert property (cpu_wr_in && idle && watchdog_enable_in
    && cpu_addr_in == 2'h0 && cpu_wdata_in != 8'h55
    && cpu_wdata_in != 8'hAA |=> sys_reset_out)
    else $error("bad service value did not reset");
  dbg_force_a:
  assert property (bdc_wr_in && idle && bdc_addr_in == 2'h1
    && bdc_wdata_in[0] |=> sys_reset_out) else $error("debug force ignored");
  hold_len_a:
  assert property ($fell(sys_reset_out) |-> hold_cnt_ff >= 9'h0C8)
    else $error("reset hold too short");
  opts_lock_a:
  assert property (!$stable(watchdog_timeout_select_out)
    |-> sys_reset_out || $past(cpu_wr_in && cpu_addr_in == 2'h2))
    else $error("options changed without write");
  iic_route_a:
  assert property (iic_on_port_a_out != iic_on_port_b_out)
    else $error("two-wire bus routed to both or none");
endmodule
bind rcsr_top rcsr_top_checker u_chk (.core_clk_in, .nrst_in, .cpu_addr_in,
  .cpu_wr_in, .cpu_rd_in, .cpu_wdata_in, .cpu_rdata_out, .bdc_wr_in,
  .bdc_addr_in, .bdc_wdata_in, .bad_opcode_in, .stop_instr_in,
  .bad_address_in, .watchdog_enable_in, .sys_reset_out,
  .stop_mode_enable_out, .watchdog_timeout_select_out, .iic_on_port_a_out,
  .iic_on_port_b_out);
`default_nettype wire

// file: testbench/rcsr_dbg_host.sv
`timescale 1ns/10ps
`default_nettype none
module rcsr_dbg_host (
  input wire logic clk_in,
  output logic bdc_wr_out,
  output logic [1:0] bdc_addr_out,
  output logic [7:0] bdc_wdata_out
);
  initial begin
    bdc_wr_out = 1'b0;
    bdc_addr_out = 2'h3;
    bdc_wdata_out = 8'hFF;
  end
  // Idle lines carry the inverse, so stale data is never seen as valid
  task automatic send(input logic [1:0] idx, input logic [7:0] val);
    bdc_addr_out = idx;
    bdc_wdata_out = val;
    bdc_wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    bdc_wr_out = 1'b0;
    bdc_addr_out = ~idx;
    bdc_wdata_out = ~val;
  endtask
endmodule
`default_nettype wire

// file: testbench/rcsr_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rcsr_top_bench;
  logic clk, nrst, wr_s, rd_s, ext_n, lv, lvre, bop, stp, bgi, bad, wen, wcs;
  logic b_wr, sysr, stop_mode_enable, pa, pb, wwm, bme, stk;
  logic [1:0] addr, b_addr, tsel;
  logic [7:0] wd, rdata, b_wd;
  int miscompares = 0;
  int checks_done = 0;
  localparam logic [7:0] CAUSE_EXP [7] =
    '{8'h10, 8'h10, 8'h10, 8'h08, 8'h40, 8'h02, 8'h00};
  rcsr_dbg_host host (.clk_in(clk), .bdc_wr_out(b_wr),
    .bdc_addr_out(b_addr), .bdc_wdata_out(b_wd));
  rcsr_top #(.WDOG_BUS_CYC3(20'h00020)) uut (.core_clk_in(clk),
    .nrst_in(nrst), .cpu_addr_in(addr), .cpu_wr_in(wr_s), .cpu_rd_in(rd_s),
    .cpu_wdata_in(wd), .cpu_rdata_out(rdata), .bdc_wr_in(b_wr),
    .bdc_addr_in(b_addr), .bdc_wdata_in(b_wd), .ext_reset_n_in(ext_n),
    .low_voltage_in(lv), .low_voltage_reset_enable_in(lvre),
    .bad_opcode_in(bop), .stop_instr_in(stp), .background_instr_in(bgi),
    .background_mode_enable_in(bme), .bad_address_in(bad),
    .watchdog_enable_in(wen), .watchdog_clock_select_in(wcs),
    .watchdog_window_mode_in(wwm), .slow_tick_in(stk),
    .sys_reset_out(sysr), .stop_mode_enable_out(stop_mode_enable),
    .watchdog_timeout_select_out(tsel), .iic_on_port_a_out(pa),
    .iic_on_port_b_out(pb));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr_s = 1'b1;
    cyc();
    wr_s = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    addr = a;
    rd_s = 1'b1;
    cyc();
    rd_s = 1'b0;
    cyc();
    chk(rdata, exp);
  endtask
  // Hold lasts about 200 cycles; the bound leaves margin
  task automatic wait_rel();
    int i;
    for (i = 0; i < 300 && sysr !== 1'b0; i++) cyc();
    if (sysr !== 1'b0) begin
      miscompares++;
      conclude();
    end
    cyc();
  endtask
  task automatic rst_case(input int k);
    case (k)
      0: bop = 1'b1;
      1: stp = 1'b1;
      2: bgi = 1'b1;
      3: bad = 1'b1;
      4: ext_n = 1'b0;
      5: lv = 1'b1;
      default: host.send(2'h1, 8'h01);
    endcase
    if (k < 6) cyc();
    {bop, stp, bgi, bad, lv} = 5'h00;
    ext_n = 1'b1;
    chk({7'h00, sysr}, 8'h01);
    wait_rel();
    rd(2'h0, CAUSE_EXP[k]);
    $display("reset source %0d done", k);
  endtask
  task automatic t_opts();
    wr(2'h2, 8'h7F);
    rd(2'h2, 8'h64);
    chk({3'h0, stop_mode_enable, tsel, pa, pb}, 8'h15);
    wr(2'h2, 8'h80);
    rd(2'h2, 8'h64);
    stp = 1'b1;
    cyc();
    stp = 1'b0;
    cyc();
    chk({7'h00, sysr}, 8'h00);
    bme = 1'b1;
    bgi = 1'b1;
    cyc();
    bgi = 1'b0;
    bme = 1'b0;
    cyc();
    chk({7'h00, sysr}, 8'h00);
    rst_case(0);
    rd(2'h2, 8'hC0);
    wr(2'h2, 8'h04);
    rd(2'h2, 8'h04);
    $display("options test done");
  endtask
  task automatic t_wdog();
    int i;
    wcs = 1'b1;
    wen = 1'b1;
    wr(2'h0, 8'h12);
    chk({7'h00, sysr}, 8'h01);
    wait_rel();
    rd(2'h0, 8'h20);
    cyc(14);
    wr(2'h0, 8'h55);
    wr(2'h0, 8'hAA);
    cyc(20);
    chk({7'h00, sysr}, 8'h00);
    rd(2'h0, 8'h20);
    for (i = 0; i < 40 && sysr !== 1'b1; i++) cyc();
    chk({7'h00, sysr}, 8'h01);
    if (sysr !== 1'b1) conclude();
    wen = 1'b0;
    wait_rel();
    rd(2'h0, 8'h20);
    cyc(100);
    chk({7'h00, sysr}, 8'h00);
    wr(2'h0, 8'h12);
    chk({7'h00, sysr}, 8'h00);
    $display("watchdog test done");
  endtask
  // Period 32 bus cycles; the service window opens at a count of 24
  task automatic t_window();
    wwm = 1'b1;
    wen = 1'b1;
    wr(2'h0, 8'h55);
    chk({7'h00, sysr}, 8'h01);
    wait_rel();
    rd(2'h0, 8'h20);
    cyc(22);
    wr(2'h0, 8'h55);
    wr(2'h0, 8'hAA);
    chk({7'h00, sysr}, 8'h00);
    cyc(8);
    chk({7'h00, sysr}, 8'h00);
    wen = 1'b0;
    wwm = 1'b0;
    $display("window test done");
  endtask
  // Slow source with select 0: expiry on the 32nd tick
  task automatic t_slow();
    int i;
    wr(2'h2, 8'h00);
    wcs = 1'b0;
    wen = 1'b1;
    for (i = 0; i < 40 && sysr !== 1'b1; i++) begin
      stk = 1'b1;
      cyc();
      stk = 1'b0;
      cyc(3);
    end
    chk(8'(i), 8'h20);
    if (sysr !== 1'b1) conclude();
    wen = 1'b0;
    wait_rel();
    rd(2'h0, 8'h20);
    $display("slow watchdog test done");
  endtask
  task automatic t_por();
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(4);
    rd(2'h0, 8'h82);
    rd(2'h2, 8'hC0);
    lv = 1'b1;
    cyc();
    lv = 1'b0;
    chk({7'h00, sysr}, 8'h01);
    wait_rel();
    rd(2'h0, 8'h82);
    {bop, bad} = 2'h3;
    cyc();
    {bop, bad} = 2'h0;
    wait_rel();
    rd(2'h0, 8'h18);
    $display("mid-run power-on test done");
  endtask
  initial begin
    {nrst, wr_s, rd_s, lv, lvre, bop, stp, bgi, bad, wen, wcs} = 11'h000;
    {wwm, bme, stk} = 3'h0;
    ext_n = 1'b1;
    addr = 2'h0;
    wd = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    cyc(4);
    lvre = 1'b1;
    rd(2'h0, 8'h82);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
    rd(2'h2, 8'hC0);
    chk({6'h00, pa, pb}, 8'h02);
    wr(2'h1, 8'h01);
    chk({7'h00, sysr}, 8'h00);
    $display("power-on test done");
    t_opts();
    for (int k = 1; k < 7; k++) rst_case(k);
    t_wdog();
    t_window();
    t_slow();
    t_por();
    conclude();
  end
endmodule
`default_nettype wire
